// ---- logic/dmi_pkg.sv ----
// constants and types for the parallel word dma interface
package dmi_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 18;
	localparam int CLK_PERIOD_NS = 8;
	localparam int BURST_TMO_NS = 2000;
	localparam int BURST_TMO_CYC = (BURST_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BURST_TWO = 2;
	localparam int CSR_ERR = 15;
	localparam int CSR_NXM = 13;
	localparam int CSR_MCR = 12;
	localparam int CSR_AC_POWER_LOW_FLAG = 11;
	localparam int CSR_PAR = 10;
	localparam int CSR_IE = 6;
	localparam int CSR_FN2 = 2;
	localparam int FL_NXM = 0;
	localparam int FL_MCR = 1;
	localparam int FL_AC_POWER_LOW_FLAG = 2;
	localparam int FL_PAR = 3;
	localparam int FL_FN2 = 4;
	localparam int FL_LATE = 5;
	localparam int FL_N = 6;
	localparam int EIR_LATE = 0;
	localparam logic [2:0] IRQ_LEVEL_RST = 3'h5;
	localparam logic [8:0] IRQ_VEC_RST = 9'h054;
	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
	localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] STEP_WORD = 18'h00002;
	localparam logic [ADDR_W-1:0] STEP_BYTE = 18'h00001;
	typedef enum logic [1:0] {DMI_XM_WORD, DMI_XM_BLOCK, DMI_XM_BURST} dmi_xmode_e;
	typedef enum logic [2:0] {DMI_IDLE, DMI_WAIT, DMI_ARB, DMI_MEM, DMI_NEXT} dmi_state_e;
endpackage

// ---- logic/dmi_flags.sv ----
// sticky status flags, set by hardware and cleared by a strobe
`timescale 1ns/1ps
module dmi_flags #(
	parameter int N = dmi_pkg::FL_N
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic [N-1:0] set,
	output logic [N-1:0] q
);
	if (N < 1) begin : g_chk
		$error("dmi_flags needs at least one flag");
	end
	for (genvar i = 0; i < N; i++) begin : g_fl
		// a set in the clearing cycle survives
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				q[i] <= 1'b0;
			end else if (set[i]) begin
				q[i] <= 1'b1;
			end else if (clr) begin
				q[i] <= 1'b0;
			end
		end
	end
endmodule // dmi_flags

// ---- logic/dmi_tmo.sv ----
// burst wait timer: pulses once when run has stood for CYC cycles
`timescale 1ns/1ps
module dmi_tmo #(
	parameter int CYC = dmi_pkg::BURST_TMO_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	output logic expired
);
	localparam int CW = $clog2(CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(CYC - 1);
	logic [CW-1:0] cnt_r;
	if (CYC < 2) begin : g_chk
		$error("dmi_tmo needs at least two cycles");
	end
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			cnt_r <= '0;
		end else if (cnt_r != LAST + CW'(1)) begin
			cnt_r <= cnt_r + CW'(1);
		end
	end
	// gated by run so no pulse appears once the wait has ended; a request in the expiring cycle is still timed out
	assign expired = run && cnt_r == LAST;
endmodule // dmi_tmo

// ---- logic/dmi_top.sv ----
// parallel word dma interface: host bus master side and peripheral handshake
`timescale 1ns/1ps
module dmi_top #(
	parameter logic [2:0] IRQ_LEVEL = dmi_pkg::IRQ_LEVEL_RST,
	parameter logic [8:0] IRQ_VEC = dmi_pkg::IRQ_VEC_RST,
	parameter int TMO_CYC = dmi_pkg::BURST_TMO_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic cfg_dir_in,
	input wire logic cfg_byte,
	input wire logic [1:0] cfg_xmode,
	input wire logic cfg_burst_n,
	input wire logic cfg_enhanced,
	input wire logic cfg_link,
	input wire logic cfg_peer_same,
	input wire logic cfg_int_en,
	input wire logic cfg_maint,
	input wire logic [dmi_pkg::ADDR_W-1:0] cfg_start_addr,
	input wire logic [dmi_pkg::DATA_W-1:0] cfg_count,
	input wire logic clr_flags,
	input wire logic ac_power_low,
	input wire logic hbus_grant,
	input wire logic mem_ack,
	input wire logic mem_nxm,
	input wire logic mem_parity_err,
	input wire logic [dmi_pkg::DATA_W-1:0] mem_rdata,
	input wire logic per_req,
	input wire logic [dmi_pkg::DATA_W-1:0] per_in_data,
	input wire logic [2:0] per_func_in,
	output logic hbus_req,
	output logic mem_req,
	output logic mem_we,
	output logic mem_byte,
	output logic [dmi_pkg::ADDR_W-1:0] mem_addr,
	output logic [dmi_pkg::DATA_W-1:0] mem_wdata,
	output logic [dmi_pkg::DATA_W-1:0] per_out_data,
	output logic per_out_hi,
	output logic per_out_lo,
	output logic per_busy,
	output logic op_active,
	output logic [dmi_pkg::DATA_W-1:0] word_count,
	output logic [dmi_pkg::DATA_W-1:0] in_data,
	output logic [2:0] func_bits,
	output logic [dmi_pkg::DATA_W-1:0] csr_status,
	output logic [dmi_pkg::DATA_W-1:0] err_info,
	output logic irq_req,
	output logic [2:0] irq_level,
	output logic [8:0] irq_vector,
	output logic burst_led
);
	dmi_pkg::dmi_state_e st_r;
	dmi_pkg::dmi_xmode_e xm_r;
	logic dir_in_r;
	logic byte_r;
	logic burst_n_r;
	logic link_r;
	logic [1:0] beats_r;
	logic [dmi_pkg::FL_N-1:0] fl_set;
	logic [dmi_pkg::FL_N-1:0] fl_q;
	logic cyc_req;
	logic last_xfer;
	logic burst_hold;
	logic tmo_run;
	logic tmo_exp;
	logic acked;

	if (TMO_CYC < 2) begin : g_chk
		$error("dmi_top timeout too short");
	end

	// internal wraparound makes its own cycle requests so no cable is needed
	assign cyc_req = per_req || (cfg_maint && st_r == dmi_pkg::DMI_WAIT);
	assign acked = st_r == dmi_pkg::DMI_MEM && mem_ack;
	assign last_xfer = word_count == {dmi_pkg::DATA_W{1'b1}} || xm_r == dmi_pkg::DMI_XM_WORD;
	// burst keeps the bus for two beats or the whole block
	assign burst_hold = xm_r == dmi_pkg::DMI_XM_BURST && (burst_n_r || beats_r < 2'(dmi_pkg::BURST_TWO - 1));
	assign tmo_run = st_r == dmi_pkg::DMI_WAIT && hbus_req && xm_r == dmi_pkg::DMI_XM_BURST;

	dmi_tmo #(.CYC(TMO_CYC)) u_tmo (
		.clk(clk),
		.rst_n(rst_n),
		.run(tmo_run),
		.expired(tmo_exp)
	);

	always_comb begin
		fl_set = '0;
		fl_set[dmi_pkg::FL_NXM] = st_r == dmi_pkg::DMI_MEM && mem_nxm;
		fl_set[dmi_pkg::FL_PAR] = acked && mem_parity_err;
		fl_set[dmi_pkg::FL_AC_POWER_LOW_FLAG] = ac_power_low;
		// overrun and late data are only monitored in enhanced mode
		fl_set[dmi_pkg::FL_MCR] = cfg_enhanced && per_req && op_active && st_r != dmi_pkg::DMI_WAIT;
		fl_set[dmi_pkg::FL_LATE] = cfg_enhanced && tmo_exp;
		fl_set[dmi_pkg::FL_FN2] = link_r && func_bits[dmi_pkg::CSR_FN2];
	end

	dmi_flags #(.N(dmi_pkg::FL_N)) u_flags (
		.clk(clk),
		.rst_n(rst_n),
		.clr(clr_flags),
		.set(fl_set),
		.q(fl_q)
	);

	// operation sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= dmi_pkg::DMI_IDLE;
		end else begin
			unique case (st_r)
				dmi_pkg::DMI_IDLE: begin
					if (go) begin
						st_r <= cfg_dir_in ? dmi_pkg::DMI_WAIT : dmi_pkg::DMI_ARB;
					end
				end
				dmi_pkg::DMI_WAIT: begin
					if (cyc_req && !tmo_exp) begin
						st_r <= dir_in_r ? dmi_pkg::DMI_ARB : dmi_pkg::DMI_NEXT;
					end
				end
				dmi_pkg::DMI_ARB: begin
					if (hbus_grant) begin
						st_r <= dmi_pkg::DMI_MEM;
					end
				end
				dmi_pkg::DMI_MEM: begin
					if (mem_nxm) begin
						st_r <= dmi_pkg::DMI_IDLE;
					end else if (mem_ack) begin
						st_r <= dir_in_r && last_xfer ? dmi_pkg::DMI_IDLE : dmi_pkg::DMI_WAIT;
					end
				end
				dmi_pkg::DMI_NEXT: begin
					// the peripheral has taken the output word; the count already stepped at the fetch
					st_r <= (word_count == '0 || xm_r == dmi_pkg::DMI_XM_WORD) ?
						dmi_pkg::DMI_IDLE : dmi_pkg::DMI_ARB;
				end
			endcase
		end
	end

	// direction and mode are frozen for the whole operation: one way at a time
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dir_in_r <= 1'b0;
			byte_r <= 1'b0;
			burst_n_r <= 1'b0;
			link_r <= 1'b0;
			xm_r <= dmi_pkg::DMI_XM_BLOCK;
		end else if (st_r == dmi_pkg::DMI_IDLE && go) begin
			dir_in_r <= cfg_dir_in;
			byte_r <= cfg_byte && !cfg_dir_in;
			burst_n_r <= cfg_burst_n;
			link_r <= cfg_link && cfg_enhanced;
			// burst without a matching enhanced peer falls back to block
			if (cfg_xmode == 2'(dmi_pkg::DMI_XM_BURST) && cfg_peer_same && cfg_enhanced) begin
				xm_r <= dmi_pkg::DMI_XM_BURST;
			end else if (cfg_xmode == 2'(dmi_pkg::DMI_XM_WORD)) begin
				xm_r <= dmi_pkg::DMI_XM_WORD;
			end else begin
				xm_r <= dmi_pkg::DMI_XM_BLOCK;
			end
		end
	end

	// address and count advance per transfer; count starts as minus the total
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_addr <= dmi_pkg::ADDR_RST;
			word_count <= dmi_pkg::WORD_RST;
		end else if (st_r == dmi_pkg::DMI_IDLE && go) begin
			mem_addr <= cfg_start_addr;
			word_count <= cfg_count;
		end else if (acked) begin
			mem_addr <= mem_addr + (byte_r ? dmi_pkg::STEP_BYTE : dmi_pkg::STEP_WORD);
			word_count <= word_count + 16'h0001;
		end
	end

	// bus mastership; block and word modes give it back after every transfer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hbus_req <= 1'b0;
			beats_r <= '0;
			burst_led <= 1'b0;
		end else begin
			if (st_r == dmi_pkg::DMI_ARB) begin
				hbus_req <= 1'b1;
			end else if (st_r == dmi_pkg::DMI_MEM && (mem_nxm || mem_ack)) begin
				hbus_req <= mem_ack && !mem_nxm && burst_hold && !last_xfer;
			end else if (tmo_exp || st_r == dmi_pkg::DMI_IDLE) begin
				hbus_req <= 1'b0;
			end
			if (st_r == dmi_pkg::DMI_IDLE) begin
				beats_r <= '0;
			end else if (acked && burst_hold) begin
				beats_r <= beats_r + 2'h1;
			end else if (acked || tmo_exp) begin
				beats_r <= '0;
			end
			burst_led <= op_active && xm_r == dmi_pkg::DMI_XM_BURST;
		end
	end

	// memory cycle strobes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_byte <= 1'b0;
		end else begin
			mem_req <= (st_r == dmi_pkg::DMI_ARB && hbus_grant) ||
				(st_r == dmi_pkg::DMI_MEM && !mem_ack && !mem_nxm);
			mem_we <= dir_in_r;
			mem_byte <= byte_r;
		end
	end

	// output register: loaded from memory, then held for the peripheral
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			per_out_data <= dmi_pkg::WORD_RST;
			per_out_hi <= 1'b0;
			per_out_lo <= 1'b0;
		end else if (acked && !dir_in_r) begin
			per_out_data <= mem_rdata;
			per_out_hi <= !byte_r || mem_addr[0];
			per_out_lo <= !byte_r || !mem_addr[0];
		end
	end

	// input register and function bits are captured together
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			in_data <= dmi_pkg::WORD_RST;
			mem_wdata <= dmi_pkg::WORD_RST;
			func_bits <= 3'h0;
		end else if (st_r == dmi_pkg::DMI_WAIT && cyc_req && dir_in_r && !tmo_exp) begin
			in_data <= cfg_maint ? per_out_data : per_in_data;
			mem_wdata <= cfg_maint ? per_out_data : per_in_data;
			func_bits <= per_func_in;
		end
	end

	// busy rises with each cycle request outside the timer's expiring cycle and falls only once data is settled
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			per_busy <= 1'b0;
			op_active <= 1'b0;
		end else begin
			op_active <= st_r != dmi_pkg::DMI_IDLE || go;
			if (st_r == dmi_pkg::DMI_IDLE) begin
				per_busy <= go && !cfg_dir_in;
			end else if (st_r == dmi_pkg::DMI_WAIT) begin
				per_busy <= cyc_req && !tmo_exp;
			end else if (st_r == dmi_pkg::DMI_MEM) begin
				per_busy <= !(mem_ack || mem_nxm);
			end else begin
				per_busy <= 1'b1;
			end
		end
	end

	// status words and interrupt request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			csr_status <= dmi_pkg::WORD_RST;
			err_info <= dmi_pkg::WORD_RST;
			irq_req <= 1'b0;
			irq_level <= dmi_pkg::IRQ_LEVEL_RST;
			irq_vector <= dmi_pkg::IRQ_VEC_RST;
		end else begin
			csr_status <= dmi_pkg::WORD_RST;
			csr_status[dmi_pkg::CSR_ERR] <= |fl_q[dmi_pkg::FL_LATE:dmi_pkg::FL_NXM] &&
				(fl_q != (dmi_pkg::FL_N)'(1 << dmi_pkg::FL_FN2));
			csr_status[dmi_pkg::CSR_NXM] <= fl_q[dmi_pkg::FL_NXM];
			csr_status[dmi_pkg::CSR_MCR] <= fl_q[dmi_pkg::FL_MCR];
			csr_status[dmi_pkg::CSR_AC_POWER_LOW_FLAG] <= fl_q[dmi_pkg::FL_AC_POWER_LOW_FLAG];
			csr_status[dmi_pkg::CSR_PAR] <= fl_q[dmi_pkg::FL_PAR];
			csr_status[dmi_pkg::CSR_IE] <= cfg_int_en;
			csr_status[2:0] <= func_bits;
			err_info <= dmi_pkg::WORD_RST;
			err_info[dmi_pkg::EIR_LATE] <= fl_q[dmi_pkg::FL_LATE];
			irq_req <= cfg_int_en && |fl_q;
			irq_level <= IRQ_LEVEL;
			irq_vector <= IRQ_VEC;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_go_starts;
		st_r == dmi_pkg::DMI_IDLE && go |=> op_active && st_r != dmi_pkg::DMI_IDLE;
	endproperty
	a_go_starts: assert property (p_go_starts) else $error("launch did not start");
	property p_busy_after_data;
		$fell(per_busy) && op_active && !dir_in_r |-> $past(mem_ack) || $past(mem_nxm);
	endproperty
	a_busy_after_data: assert property (p_busy_after_data) else $error("busy fell early");
	property p_odr_load;
		acked && !dir_in_r |=> per_out_data == $past(mem_rdata);
	endproperty
	a_odr_load: assert property (p_odr_load) else $error("output register not loaded");
	property p_loopback;
		st_r == dmi_pkg::DMI_WAIT && dir_in_r && cfg_maint && !tmo_exp |=> in_data == per_out_data;
	endproperty
	a_loopback: assert property (p_loopback) else $error("loopback word differs");
	property p_block_release;
		acked && xm_r == dmi_pkg::DMI_XM_BLOCK |=> !hbus_req;
	endproperty
	a_block_release: assert property (p_block_release) else $error("block kept bus");
	property p_irq_gate;
		irq_req |-> $past(cfg_int_en) && $past(|fl_q);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");
	property p_nxm_irq;
		fl_set[dmi_pkg::FL_NXM] && cfg_int_en && !clr_flags ##1 cfg_int_en |=> irq_req;
	endproperty
	a_nxm_irq: assert property (p_nxm_irq) else $error("no-memory interrupt missing");
	property p_tmo_release;
		tmo_exp |=> !hbus_req ##0 (st_r != dmi_pkg::DMI_MEM);
	endproperty
	a_tmo_release: assert property (p_tmo_release) else $error("timeout kept bus");
	property p_addr_step;
		acked && !byte_r |=> mem_addr == $past(mem_addr) + dmi_pkg::STEP_WORD
			&& word_count == $past(word_count) + 16'h0001;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address or count step wrong");
	property p_led;
		burst_led |-> $past(xm_r) == dmi_pkg::DMI_XM_BURST;
	endproperty
	a_led: assert property (p_led) else $error("burst indicator wrong");

	c_burst_two: cover property (acked && xm_r == dmi_pkg::DMI_XM_BURST ##[1:40] acked);
	c_timeout: cover property (tmo_exp);
	c_input_done: cover property (acked && dir_in_r && last_xfer);
endmodule // dmi_top

// ---- test/dmi_far.sv ----
// host bus, memory and peripheral model facing the dma interface
`timescale 1ns/1ps
module dmi_far (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic slow,
	input wire logic per_en,
	input wire logic nxm_en,
	input wire logic [15:0] in_base,
	input wire logic [2:0] fn,
	input wire logic hbus_req,
	input wire logic mem_req,
	input wire logic [17:0] mem_addr,
	input wire logic per_busy,
	input wire logic op_active,
	output logic hbus_grant,
	output logic mem_ack,
	output logic mem_nxm,
	output logic [15:0] mem_rdata,
	output logic per_req,
	output logic [15:0] per_in_data,
	output logic [2:0] per_func_in
);
	logic [2:0] dly_r;
	logic [2:0] gap_r;
	logic [15:0] idx_r;
	logic [15:0] junk_r;
	always_ff @(posedge clk) begin
		hbus_grant <= rst_n && hbus_req;
	end
	// a slow host answers four cycles after the request instead of one
	always_ff @(posedge clk) begin
		if (!rst_n || !mem_req || mem_ack || mem_nxm) begin
			dly_r <= 3'h0;
			mem_ack <= 1'b0;
			mem_nxm <= 1'b0;
		end else begin
			dly_r <= dly_r + 3'h1;
			mem_ack <= !nxm_en && dly_r == (slow ? 3'h3 : 3'h0);
			mem_nxm <= nxm_en && dly_r == (slow ? 3'h3 : 3'h0);
		end
	end
	// read data is only meaningful with the acknowledge
	assign mem_rdata = mem_ack ? (mem_addr[15:0] ^ 16'h5a3c) : ~(mem_addr[15:0] ^ 16'h5a3c);
	// requests only while busy is low, then a gap so one word is never taken twice
	always_ff @(posedge clk) begin
		junk_r <= rst_n ? junk_r + 16'h1357 : 16'h0000;
		if (!rst_n || go) begin
			per_req <= 1'b0;
			gap_r <= 3'h0;
			idx_r <= 16'h0000;
		end else if (per_req) begin
			per_req <= 1'b0;
			idx_r <= idx_r + 16'h0001;
			gap_r <= slow ? 3'h6 : 3'h3;
		end else if (gap_r != 3'h0) begin
			gap_r <= gap_r - 3'h1;
		end else begin
			per_req <= per_en && op_active && !per_busy;
		end
	end
	assign per_in_data = per_req ? in_base + idx_r : junk_r;
	assign per_func_in = per_req ? fn : ~fn;
endmodule // dmi_far

// ---- test/parallel_dma_word_interface_bench.sv ----
// self-checking bench for the parallel word dma interface
`timescale 1ns/1ps
module parallel_dma_word_interface_bench;
	logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, dir_in = 1'b0, byt = 1'b0, burst_n = 1'b0;
	logic enh = 1'b0, link = 1'b0, peer = 1'b0, int_en = 1'b0, maint = 1'b0, clr = 1'b0;
	logic ac_power_low_flag = 1'b0, slow = 1'b0, per_en = 1'b1, nxm_en = 1'b0, hreq_d = 1'b0, led_seen;
	logic par = 1'b0, mbyte;
	logic [1:0] xm = 2'h1;
	logic [17:0] addr = 18'h00000;
	logic [15:0] cnt = 16'hffff, base = 16'h0000;
	logic [2:0] fn = 3'h1;
	logic grant, ack, nxm, preq, hreq, mreq, mwe, hi, lo, busy, act, irq, led;
	logic [15:0] rdata, pin, pout, wdata, wcnt, indata, csr, eir;
	logic [17:0] maddr;
	logic [2:0] pfn, fbits, ilvl;
	logic [8:0] ivec;
	logic [35:0] exp_q[$];
	integer seed = 32'hcaeb1967;
	int bad_count = 0, samples_checked = 0, rises = 0;

	always #4 clk = ~clk;

	dmi_top #(.TMO_CYC(8)) dut (.clk(clk), .rst_n(rst_n), .go(go), .cfg_dir_in(dir_in),
		.cfg_byte(byt), .cfg_xmode(xm), .cfg_burst_n(burst_n), .cfg_enhanced(enh),
		.cfg_link(link), .cfg_peer_same(peer), .cfg_int_en(int_en), .cfg_maint(maint),
		.cfg_start_addr(addr), .cfg_count(cnt), .clr_flags(clr), .ac_power_low(ac_power_low_flag),
		.hbus_grant(grant), .mem_ack(ack), .mem_nxm(nxm), .mem_parity_err(par),
		.mem_rdata(rdata), .per_req(preq), .per_in_data(pin), .per_func_in(pfn),
		.hbus_req(hreq), .mem_req(mreq), .mem_we(mwe), .mem_byte(mbyte), .mem_addr(maddr),
		.mem_wdata(wdata), .per_out_data(pout), .per_out_hi(hi), .per_out_lo(lo),
		.per_busy(busy), .op_active(act), .word_count(wcnt), .in_data(indata),
		.func_bits(fbits), .csr_status(csr), .err_info(eir), .irq_req(irq),
		.irq_level(ilvl), .irq_vector(ivec), .burst_led(led));

	dmi_far far (.clk(clk), .rst_n(rst_n), .go(go), .slow(slow), .per_en(per_en),
		.nxm_en(nxm_en), .in_base(base), .fn(fn), .hbus_req(hreq), .mem_req(mreq),
		.mem_addr(maddr), .per_busy(busy), .op_active(act), .hbus_grant(grant),
		.mem_ack(ack), .mem_nxm(nxm), .mem_rdata(rdata), .per_req(preq),
		.per_in_data(pin), .per_func_in(pfn));

	task automatic test_done();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [35:0] seen, input logic [35:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, want, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_for(ref logic s, input logic v);
		int n = 0;
		while (s !== v && n < 3000) begin
			tick(1);
			n++;
		end
		if (n == 3000) begin
			check("bounded wait", 36'h1, 36'h0);
			test_done();
		end
	endtask

	// notes every expected transfer, launches, then checks count and final address
	task automatic run_op(input logic d, input int n, input logic [17:0] a, input logic chk);
		logic [17:0] step;
		logic [17:0] ai;
		int k;
		step = (byt && !d) ? 18'h00001 : 18'h00002;
		k = (xm == 2'h0) ? 1 : n;
		dir_in = d;
		addr = a;
		cnt = 16'(-n);
		for (int i = 0; i < k && chk; i++) begin
			ai = 18'(a + step * i);
			if (d) exp_q.push_back({2'b01, ai, 16'(base + i)});
			else exp_q.push_back({18'h0, byt ? {ai[0], !ai[0]} : 2'b11, ai[15:0] ^ 16'h5a3c});
		end
		rises = 0;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		wait_for(act, 1'b0);
		tick(2);
		if (chk) begin
			check("pending", 36'(exp_q.size()), 36'h0);
			check("count", wcnt, 16'(cnt + k));
			check("address", maddr, 18'(a + step * k));
			check("byte strobe", mbyte, byt && !d);
		end
	endtask

	// compares each word taken by the peripheral or written to memory with the oldest note
	always @(posedge clk) begin
		hreq_d <= hreq;
		if (rst_n && hreq && !hreq_d) rises++;
		if (led) led_seen = 1'b1;
		if (rst_n && ((preq && !dir_in) || (ack && mwe))) begin
			if (exp_q.size() == 0) check("unexpected", 36'h1, 36'h0);
			else if (ack && mwe) check("mem write", {2'b01, maddr, wdata}, exp_q.pop_front());
			else check("out word", {18'h0, hi, lo, pout}, exp_q.pop_front());
		end
	end

	initial begin
		tick(12);
		rst_n = 1'b1;
		tick(1);
		check("level", ilvl, 3'h5);
		check("vector", ivec, 9'h054);
		check("idle irq", irq, 1'b0);
		enh = 1'b1;
		peer = 1'b1;
		for (int m = 0; m < 3; m++) begin
			xm = (m == 0) ? 2'h1 : 2'h2;
			burst_n = (m == 2);
			byt = (m == 1);
			led_seen = 1'b0;
			run_op(1'b0, 4, (m == 0) ? 18'h3fffc : 18'($random(seed)) & 18'h3fffe, 1'b1);
			check("bus grabs", rises, (m == 0) ? 4 : (m == 1) ? 2 : 1);
			check("burst led", led_seen, m != 0);
		end
		byt = 1'b0;
		xm = 2'h1;
		slow = 1'b1;
		fn = 3'h3;
		base = 16'($random(seed));
		run_op(1'b1, 3, 18'h3fffc, 1'b1);
		check("func bits", fbits, 3'h3);
		check("in data", indata, 16'(base + 2));
		slow = 1'b0;
		xm = 2'h0;
		par = 1'b1;
		run_op(1'b0, 3, 18'h00100, 1'b1);
		par = 1'b0;
		check("parity", csr[10], 1'b1);
		// loopback must return the word left in the output register
		base = 16'h0100 ^ 16'h5a3c;
		maint = 1'b1;
		per_en = 1'b0;
		run_op(1'b1, 1, 18'h00200, 1'b1);
		check("loop in", indata, base);
		maint = 1'b0;
		per_en = 1'b1;
		xm = 2'h2;
		burst_n = 1'b1;
		fork
			run_op(1'b1, 2, 18'h00300, 1'b1);
			begin
				wait_for(ack, 1'b1);
				per_en = 1'b0;
				wait_for(hreq, 1'b0);
				tick(2);
				check("late flag", eir[0], 1'b1);
				per_en = 1'b1;
			end
		join
		int_en = 1'b1;
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		ac_power_low_flag = 1'b1;
		tick(1);
		ac_power_low_flag = 1'b0;
		wait_for(irq, 1'b1);
		check("power low", csr[11], 1'b1);
		check("summary", csr[15], 1'b1);
		check("ie bit", csr[6], 1'b1);
		int_en = 1'b0;
		tick(3);
		check("masked irq", irq, 1'b0);
		int_en = 1'b1;
		nxm_en = 1'b1;
		per_en = 1'b0;
		xm = 2'h1;
		run_op(1'b0, 2, 18'h00400, 1'b0);
		check("no memory", csr[13], 1'b1);
		check("nxm irq", irq, 1'b1);
		nxm_en = 1'b0;
		per_en = 1'b1;
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(2);
		check("cleared", csr[13], 1'b0);
		link = 1'b1;
		fn = 3'h4;
		run_op(1'b1, 1, 18'h00600, 1'b1);
		check("fn2 bit", csr[2], 1'b1);
		check("fn2 irq", irq, 1'b1);
		check("fn2 summary", csr[15], 1'b0);
		test_done();
	end
endmodule // parallel_dma_word_interface_bench
